// *** core/acs_osc_div.sv ***
module acs_osc_div
  import acs_pkg::*;
(
  input  wire logic clk,     // system clock
  input  wire logic nrst,    // sync reset, active low
  output logic      modTick, // one-cycle pulse per modulator period
  output logic      modClk   // modulator clock, square wave
);

  localparam int MOD_PER = OSC_DIV * MOD_DIV;

  logic [4:0] oscCnt_reg;
  logic [1:0] phase_reg;
  logic       modTick_reg;
  logic       modClk_reg;
  logic       oscTick;

  assign oscTick = (oscCnt_reg == 5'(OSC_DIV - 1));

  always_ff @(posedge clk) begin
    if (!nrst) oscCnt_reg <= 5'h00;
    else oscCnt_reg <= oscTick ? 5'h00 : oscCnt_reg + 5'h01;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_reg   <= 2'h0;
      modTick_reg <= 1'b0;
      modClk_reg  <= 1'b0;
    end else begin
      modTick_reg <= oscTick && (phase_reg == 2'(MOD_DIV - 1));
      if (oscTick) begin
        phase_reg  <= phase_reg + 2'h1;
        modClk_reg <= (phase_reg == 2'(MOD_DIV - 1)) || (phase_reg == 2'h0);
      end
    end
  end

  assign modTick = modTick_reg;
  assign modClk  = modClk_reg;

  property p_mod_period;
    @(posedge clk) disable iff (!nrst) modTick |-> ##MOD_PER modTick;
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("modulator period wrong");

  property p_mod_gap;
    @(posedge clk) disable iff (!nrst) modTick |=> !modTick [*8];
  endproperty
  a_mod_gap: assert property (p_mod_gap) else $error("modulator ticks too close");

endmodule : acs_osc_div

// *** core/acs_result_store.sv ***
module acs_result_store
  import acs_pkg::*;
(
  input  wire logic                    clk,         // system clock
  input  wire logic                    nrst,        // sync reset, active low
  input  wire logic                    finish,      // conversion ends this cycle
  input  wire logic signed [ACC_W-1:0] accFinal,    // bitstream sum of the conversion
  input  wire logic        [2:0]       rateSel,     // rate of the conversion
  input  wire logic                    singleEnded, // conversion was single-ended
  output logic             [RES_W-1:0] result,      // latest result code
  output logic                         resultNew    // one-cycle pulse on update
);

  logic [RES_W-1:0] result_reg;
  logic             resultNew_reg;
  logic             seHeld_reg;
  logic signed [ACC_W+SCALE_W:0] prod;
  logic signed [ACC_W+SCALE_W:0] scaled;
  logic [RES_W-1:0] code;

  // step is full scale over 2^11
  always_comb begin
    prod   = accFinal * $signed({1'b0, scaleFor(rateSel)});
    scaled = prod >>> SCALE_SH;
    if (scaled > (2 ** (RES_W - 1)) - 1) code = {1'b0, {(RES_W-1){1'b1}}};
    else if (scaled < -(2 ** (RES_W - 1))) code = {1'b1, {(RES_W-1){1'b0}}};
    else code = scaled[RES_W-1:0];
    if (singleEnded && code[RES_W-1]) code = '0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      result_reg    <= '0;
      resultNew_reg <= 1'b0;
      seHeld_reg    <= 1'b0;
    end else begin
      resultNew_reg <= finish;
      if (finish) begin
        result_reg <= code;
        seHeld_reg <= singleEnded;
      end
    end
  end

  assign result    = result_reg;
  assign resultNew = resultNew_reg;

  property p_se_nonneg;
    @(posedge clk) disable iff (!nrst) seHeld_reg |-> !result_reg[RES_W-1];
  endproperty
  a_se_nonneg: assert property (p_se_nonneg) else $error("negative single-ended code");

  property p_hold;
    @(posedge clk) disable iff (!nrst) !finish |=> $stable(result_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without conversion");

endmodule : acs_result_store

// *** core/acs_sequencer.sv ***
// Decided for this implementation: the register addresses and the AHB-Lite register port.
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        clk,        // 20 MHz system clock
  input  wire logic        nrst,       // sync reset, active low
  input  wire logic        hsel,       // AHB-Lite select
  input  wire logic [31:0] haddr,      // AHB-Lite address
  input  wire logic [1:0]  htrans,     // AHB-Lite transfer type
  input  wire logic        hwrite,     // AHB-Lite write
  input  wire logic [2:0]  hsize,      // AHB-Lite size, word only
  input  wire logic [31:0] hwdata,     // AHB-Lite write data
  input  wire logic        hready,     // AHB-Lite bus ready
  output logic             hreadyout,  // AHB-Lite slave ready
  output logic             hresp,      // AHB-Lite response, always OKAY
  output logic      [31:0] hrdata,     // AHB-Lite read data
  input  wire logic        modBit,     // modulator bitstream
  output logic             modClk,     // modulator clock
  output logic      [2:0]  muxSel,     // active input selection
  output logic             negToGnd,   // negative input to ground switch
  output logic      [2:0]  gainSel,    // active full-scale range
  output logic             convPower   // analog front end powered
);

  // ********************************
  // declarations
  // ********************************
  acs_state_type state_reg;

  logic                    cfgMode_reg;
  logic [2:0]              cfgMux_reg;
  logic [2:0]              cfgGain_reg;
  logic [2:0]              cfgRate_reg;
  logic                    ssPending_reg;
  logic                    newData_reg;
  logic [2:0]              actMux_reg;
  logic [2:0]              actGain_reg;
  logic [2:0]              actRate_reg;
  logic [TICK_W-1:0]       actTicks_reg;
  logic [TICK_W-1:0]       tickCnt_reg;
  logic signed [ACC_W-1:0] acc_reg;
  logic                    wrPend_reg;
  logic [7:0]              wrAddr_reg;
  logic [31:0]             hrdata_reg;
  logic                    hreadyout_reg;
  logic                    hresp_reg;
  logic                    negToGnd_reg;
  logic                    convPower_reg;
  logic [RES_W-1:0]        result;
  logic                    resultNew;
  logic                    modTick;
  logic                    accept;
  logic                    cfgWrite;
  logic                    rdResult;
  logic                    startReq;
  logic                    lastTick;
  logic                    restart;
  logic                    load;
  logic signed [ACC_W-1:0] accNext;

  // ********************************
  // helpers
  // ********************************
  acs_osc_div u_div (
    .clk     (clk),
    .nrst    (nrst),
    .modTick (modTick),
    .modClk  (modClk)
  );

  acs_result_store u_res (
    .clk         (clk),
    .nrst        (nrst),
    .finish      (lastTick),
    .accFinal    (accNext),
    .rateSel     (actRate_reg),
    .singleEnded (isSingleEnded(actMux_reg)),
    .result      (result),
    .resultNew   (resultNew)
  );

  // ********************************
  // bus slave
  // ********************************
  assign accept   = hsel && htrans[1] && hready;
  assign cfgWrite = wrPend_reg && (wrAddr_reg == OFS_CONFIG);
  assign rdResult = accept && !hwrite && (haddr[7:0] == OFS_RESULT);

  function automatic logic [31:0] readMux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      OFS_CONFIG: begin
        d[POS_MODE]          = cfgMode_reg;
        d[POS_SS]            = ssPending_reg;
        d[POS_MUX +: 3]      = cfgMux_reg;
        d[POS_GAIN +: 3]     = cfgGain_reg;
        d[POS_RATE +: 3]     = cfgRate_reg;
      end
      OFS_RESULT: d[RES_W-1:0] = result;
      OFS_STATUS: begin
        d[POS_BUSY] = (state_reg == ST_CONV);
        d[POS_NEW]  = newData_reg;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : readMux

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPend_reg    <= 1'b0;
      wrAddr_reg    <= 8'h00;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      wrPend_reg    <= accept && hwrite;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      if (accept) wrAddr_reg <= haddr[7:0];
      if (accept && !hwrite) hrdata_reg <= readMux(haddr[7:0]);
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign hrdata    = hrdata_reg;

  // ********************************
  // configuration
  // ********************************
  // gain and rate codes are cleaned on write so reads show what runs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfgMode_reg <= RST_MODE;
      cfgMux_reg  <= RST_MUX;
      cfgGain_reg <= RST_GAIN;
      cfgRate_reg <= RST_RATE;
    end else if (cfgWrite) begin
      cfgMode_reg <= hwdata[POS_MODE];
      cfgMux_reg  <= hwdata[POS_MUX +: 3];
      cfgGain_reg <= safeGain(hwdata[POS_GAIN +: 3]);
      cfgRate_reg <= safeRate(hwdata[POS_RATE +: 3]);
    end
  end

  // a trigger while converting or in continuous mode is dropped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ssPending_reg <= 1'b0;
    end else if (startReq) begin
      ssPending_reg <= 1'b0;
    end else if (cfgWrite && hwdata[POS_SS] && hwdata[POS_MODE] &&
                 state_reg == ST_PDOWN) begin
      ssPending_reg <= 1'b1;
    end
  end

  // set wins over a read of the result
  always_ff @(posedge clk) begin
    if (!nrst) newData_reg <= 1'b0;
    else if (resultNew) newData_reg <= 1'b1;
    else if (rdResult) newData_reg <= 1'b0;
  end

  // ********************************
  // conversion sequencer
  // ********************************
  assign startReq = (state_reg == ST_PDOWN) && (!cfgMode_reg || ssPending_reg);
  assign lastTick = (state_reg == ST_CONV) && modTick &&
                    (tickCnt_reg == actTicks_reg - TICK_W'(1));
  assign restart  = lastTick && !cfgMode_reg;
  assign load     = startReq || restart;
  assign accNext  = modBit ? acc_reg + ACC_W'(1) : acc_reg - ACC_W'(1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_PDOWN;
    end else begin
      case (state_reg)
        ST_PDOWN: if (startReq) state_reg <= ST_CONV;
        ST_CONV: if (lastTick && cfgMode_reg) state_reg <= ST_PDOWN;
        default: state_reg <= ST_PDOWN;
      endcase
    end
  end

  // settings are frozen for the length of one conversion
  always_ff @(posedge clk) begin
    if (!nrst) begin
      actMux_reg   <= RST_MUX;
      actGain_reg  <= RST_GAIN;
      actRate_reg  <= RST_RATE;
      actTicks_reg <= ticksFor(RST_RATE);
    end else if (load) begin
      actMux_reg   <= cfgMux_reg;
      actGain_reg  <= cfgGain_reg;
      actRate_reg  <= cfgRate_reg;
      actTicks_reg <= ticksFor(cfgRate_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tickCnt_reg <= '0;
      acc_reg     <= '0;
    end else if (load) begin
      tickCnt_reg <= '0;
      acc_reg     <= '0;
    end else if (state_reg == ST_CONV && modTick) begin
      tickCnt_reg <= tickCnt_reg + TICK_W'(1);
      acc_reg     <= accNext;
    end
  end

  // ********************************
  // analog controls
  // ********************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      negToGnd_reg  <= isSingleEnded(RST_MUX);
      convPower_reg <= 1'b0;
    end else begin
      negToGnd_reg  <= isSingleEnded(load ? cfgMux_reg : actMux_reg);
      convPower_reg <= load || (state_reg == ST_CONV && !(lastTick && cfgMode_reg));
    end
  end

  assign muxSel    = actMux_reg;
  assign gainSel   = actGain_reg;
  assign negToGnd  = negToGnd_reg;
  assign convPower = convPower_reg;

  // ********************************
  // checks
  // ********************************
  logic [23:0] gapCnt_reg;
  logic        prevRestart_reg;

  always_ff @(posedge clk) begin
    if (!nrst || load) gapCnt_reg <= '0;
    else gapCnt_reg <= gapCnt_reg + 24'h000001;
  end

  always_ff @(posedge clk) begin
    if (!nrst || startReq) prevRestart_reg <= 1'b0;
    else if (restart) prevRestart_reg <= 1'b1;
  end

  sequence s_ss_write;
    cfgWrite && hwdata[POS_SS] && hwdata[POS_MODE] &&
    state_reg == ST_PDOWN && !ssPending_reg;
  endsequence

  sequence s_ss_start;
    ssPending_reg ##1 (state_reg == ST_CONV && !ssPending_reg);
  endsequence

  property p_ss_start;
    @(posedge clk) disable iff (!nrst) s_ss_write |=> s_ss_start;
  endproperty
  a_ss_start: assert property (p_ss_start) else $error("trigger did not start");

  property p_single_end;
    @(posedge clk) disable iff (!nrst)
      lastTick && cfgMode_reg |=> state_reg == ST_PDOWN && resultNew && !convPower;
  endproperty
  a_single_end: assert property (p_single_end) else $error("no power down");

  property p_cont_next;
    @(posedge clk) disable iff (!nrst)
      lastTick && !cfgMode_reg |=> state_reg == ST_CONV && tickCnt_reg == '0 && resultNew;
  endproperty
  a_cont_next: assert property (p_cont_next) else $error("no automatic restart");

  property p_rate;
    @(posedge clk) disable iff (!nrst)
      lastTick && prevRestart_reg |->
        gapCnt_reg == 24'(int'(actTicks_reg) * OSC_DIV * MOD_DIV - 1);
  endproperty
  a_rate: assert property (p_rate) else $error("result rate wrong");

  property p_se_switch;
    @(posedge clk) disable iff (!nrst) negToGnd == isSingleEnded(muxSel);
  endproperty
  a_se_switch: assert property (p_se_switch) else $error("ground switch wrong");

  property p_gain_legal;
    @(posedge clk) disable iff (!nrst) gainSel <= GAIN_MAX && actRate_reg <= RATE_MAX;
  endproperty
  a_gain_legal: assert property (p_gain_legal) else $error("unused code active");

  property p_reset;
    @(posedge clk) $rose(nrst) |-> state_reg == ST_PDOWN && cfgMode_reg && !convPower;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_mode;
    @(posedge clk) disable iff (!nrst) cfgWrite |=> cfgMode_reg == $past(hwdata[POS_MODE]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit not stored");

  property p_ss_refused;
    @(posedge clk) disable iff (!nrst) cfgWrite && state_reg == ST_CONV |=> !ssPending_reg;
  endproperty
  a_ss_refused: assert property (p_ss_refused) else $error("trigger taken while busy");

  property p_mux_load;
    @(posedge clk) disable iff (!nrst) load |=> muxSel == $past(cfgMux_reg);
  endproperty
  a_mux_load: assert property (p_mux_load) else $error("input select not applied");

  property p_gain_load;
    @(posedge clk) disable iff (!nrst) load |=> gainSel == $past(cfgGain_reg);
  endproperty
  a_gain_load: assert property (p_gain_load) else $error("gain range not applied");

  property p_power;
    @(posedge clk) disable iff (!nrst) convPower == (state_reg == ST_CONV);
  endproperty
  a_power: assert property (p_power) else $error("power state wrong");

endmodule : acs_sequencer

// *** pkg/acs_pkg.sv ***
package acs_pkg;

  // ********************************
  // clocking
  // ********************************
  localparam int CLK_HZ  = 20_000_000;
  localparam int OSC_HZ  = 1_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int MOD_DIV = 4;
  localparam int MOD_HZ  = OSC_HZ / MOD_DIV;

  // ********************************
  // register map and fields
  // ********************************
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int POS_MODE = 0;
  localparam int POS_SS   = 1;
  localparam int POS_MUX  = 2;
  localparam int POS_GAIN = 5;
  localparam int POS_RATE = 8;
  localparam int POS_BUSY = 0;
  localparam int POS_NEW  = 1;

  // ********************************
  // reset values and code limits
  // ********************************
  localparam logic       RST_MODE     = 1'h1;
  localparam logic [2:0] RST_MUX      = 3'h0;
  localparam logic [2:0] RST_GAIN     = 3'h2;
  localparam logic [2:0] RST_RATE     = 3'h4;
  localparam logic [2:0] GAIN_MAX     = 3'h5;
  localparam logic [2:0] RATE_MAX     = 3'h6;
  localparam logic [2:0] MUX_SE_FIRST = 3'h4;
  localparam int RES_W    = 12;
  localparam int ACC_W    = 13;
  localparam int TICK_W   = 11;
  localparam int SCALE_W  = 21;
  localparam int SCALE_SH = 16;
  localparam int RATE_SPS [0:6] = '{128, 250, 490, 920, 1600, 2400, 3300};

  typedef enum logic [1:0] {
    ST_PDOWN = 2'b01,
    ST_CONV  = 2'b10
  } acs_state_type;

  function automatic logic [2:0] safeRate(input logic [2:0] r);
    return (r > RATE_MAX) ? RST_RATE : r;
  endfunction : safeRate

  function automatic logic [2:0] safeGain(input logic [2:0] g);
    return (g > GAIN_MAX) ? RST_GAIN : g;
  endfunction : safeGain

  function automatic logic isSingleEnded(input logic [2:0] m);
    return m >= MUX_SE_FIRST;
  endfunction : isSingleEnded

  // modulator ticks in one conversion at the given rate
  function automatic logic [TICK_W-1:0] ticksFor(input logic [2:0] r);
    return TICK_W'(MOD_HZ / RATE_SPS[safeRate(r)]);
  endfunction : ticksFor

  function automatic logic [SCALE_W-1:0] scaleFor(input logic [2:0] r);
    return SCALE_W'((2 ** (RES_W - 1 + SCALE_SH)) / int'(ticksFor(r)));
  endfunction : scaleFor

endpackage : acs_pkg

// *** test/acs_mod_model.sv ***
module acs_mod_model (
  input  wire logic clk,    // system clock
  input  wire logic nrst,   // sync reset, active low
  input  wire logic modClk, // modulator clock from the block
  input  wire logic level,  // input at full scale, 1 positive, 0 negative
  output logic      modBit  // modulator bitstream
);
  timeunit 1ns;
  timeprecision 1ns;

  logic modClkPrev_reg;

  // a full-scale input keeps the modulator at one level, so the code is exact
  always_ff @(posedge clk) begin
    if (!nrst) begin
      modClkPrev_reg <= 1'b0;
      modBit         <= 1'b0;
    end else begin
      modClkPrev_reg <= modClk;
      if (modClk && !modClkPrev_reg) begin
        modBit <= level;
      end
    end
  end
endmodule : acs_mod_model

// *** test/test_adc_conversion_sequencer.sv ***
module test_adc_conversion_sequencer
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, nrst, hsel, hwrite, hready, hreadyout, hresp, level;
  logic        modBit, modClk, negToGnd, convPower;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize, muxSel, gainSel;
  int          err_count, checks_done, cyc, t0, dur, hi, lo;
  int          expQ[$];

  assign hready = hreadyout;

  acs_sequencer u_acs_sequencer (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .modBit(modBit),
    .modClk(modClk), .muxSel(muxSel), .negToGnd(negToGnd), .gainSel(gainSel),
    .convPower(convPower));

  acs_mod_model u_acs_mod_model (.clk(clk), .nrst(nrst), .modClk(modClk), .level(level),
    .modBit(modBit));

  always #25 clk = ~clk;

  always @(posedge clk) cyc <= cyc + 1;

  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrNext

  function automatic logic [31:0] cfgWord(input int mode, mux, gain, rate);
    return 32'((mode << POS_MODE) | (mux << POS_MUX) | (gain << POS_GAIN) | (rate << POS_RATE));
  endfunction : cfgWord

  // full-scale code, clipped at zero for single-ended selections
  function automatic int expCode(input int lvl, input int mux);
    int v;
    v = lvl ? 2047 : -2048;
    if (mux >= 4 && v < 0) v = 0;
    return v & 32'h0000_0FFF;
  endfunction : expCode

  task checkVal(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal

  task checkIn(input int got, input int low, input int high);
    checks_done++;
    if (got < low || got > high) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h..%h", $time, got, low, high);
    end
  endtask : checkIn

  // one single transfer; read data left in rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    checkVal(32'(hresp), 32'h0);
  endtask : bus

  task waitPow(input logic v, input int lim);
    int n;
    n = 0;
    while (convPower !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) checkVal(32'(convPower), 32'(v));
  endtask : waitPow

  task pollNew();
    int g;
    g = 0;
    do begin
      bus(1'b0, 32'(OFS_STATUS), 32'h0);
      g++;
    end while (rd[POS_NEW] !== 1'b1 && g < 5000);
    checkVal(32'(rd[POS_NEW]), 32'h1);
  endtask : pollNew

  // one single-shot conversion, optionally retriggered while it runs
  task single(input int mux, input int gain, input int rate, input int lvl, input int retrig);
    int          n;
    logic [31:0] cfg;
    n   = MOD_HZ / RATE_SPS[rate];
    cfg = cfgWord(1, mux, gain, rate);
    level <= lvl[0];
    expQ.push_back(expCode(lvl, mux));
    // the bitstream only follows the level at a modulator edge, so let one pass first
    repeat (90) @(posedge clk);
    bus(1'b1, 32'(OFS_CONFIG), cfg | 32'h2);
    waitPow(1'b1, 10);
    t0 = cyc;
    checkVal(32'(muxSel), 32'(mux));
    checkVal(32'(negToGnd), mux >= 4);
    checkVal(32'(gainSel), 32'(gain));
    if (retrig) bus(1'b1, 32'(OFS_CONFIG), cfg | 32'h2);
    waitPow(1'b0, 20000);
    dur = cyc - t0;
    checkIn(dur, n * 80 - 80, n * 80 + 80);
    bus(1'b0, 32'(OFS_RESULT), 32'h0);
    checkVal(rd, expQ.pop_front());
    bus(1'b0, 32'(OFS_STATUS), 32'h0);
    checkVal(rd, 32'h0);
    bus(1'b0, 32'(OFS_CONFIG), 32'h0);
    checkVal(rd, cfg);
  endtask : single

  task stop_test();
    $display("checks done %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // ********************************
  // watchdog
  // ********************************
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    $display("watchdog expired at %0t ns", $time);
    stop_test();
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    clk = 1'b0; nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; level = 1'b0; seed = 32'hF4D396FE;
    err_count = 0; checks_done = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    checkVal(32'(convPower), 32'h0);
    checkVal(32'(gainSel), 32'h2);
    bus(1'b0, 32'(OFS_CONFIG), 32'h0);
    checkVal(rd, 32'h0000_0441);
    bus(1'b0, 32'(OFS_RESULT), 32'h0);
    checkVal(rd, 32'h0);
    seed = lfsrNext(seed);
    bus(1'b0, ((seed % 60) + 3) * 4, 32'h0);
    checkVal(rd, 32'h0);
    $display("reset and map test done");

    // out-of-range codes fall back to the defaults
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 32'(OFS_CONFIG), cfgWord(1, 0, i, i));
      bus(1'b0, 32'(OFS_CONFIG), 32'h0);
      checkVal(rd, cfgWord(1, 0, i > 5 ? 2 : i, i > 6 ? 4 : i));
    end
    $display("field code test done");

    for (int i = 0; i < 8; i++) begin
      seed = lfsrNext(seed);
      single(i, i % 6, 6, int'(seed[0]), 0);
    end
    $display("input select test done");

    single(1, 2, 5, 1, 1);
    repeat (100) @(posedge clk);
    checkVal(32'(convPower), 32'h0);
    $display("retrigger test done");

    level <= 1'b1;
    bus(1'b1, 32'(OFS_CONFIG), cfgWord(0, 0, 2, 6));
    waitPow(1'b1, 10);
    hi = 0;
    lo = 0;
    while (modClk !== 1'b1 && lo < 200) begin @(posedge clk); lo++; end
    while (modClk !== 1'b0 && lo < 200) begin @(posedge clk); lo++; end
    lo = 0;
    while (modClk === 1'b0 && lo < 200) begin @(posedge clk); lo++; end
    while (modClk === 1'b1 && hi < 200) begin @(posedge clk); hi++; end
    checkVal(32'(hi), 32'd40);
    checkVal(32'(lo), 32'd40);
    pollNew();
    t0 = cyc;
    bus(1'b0, 32'(OFS_RESULT), 32'h0);
    checkVal(rd, 32'h0000_07FF);
    pollNew();
    dur = cyc - t0;
    checkIn(dur, 6000 - 6, 6000 + 6);
    checkVal(32'(convPower), 32'h1);
    bus(1'b1, 32'(OFS_CONFIG), cfgWord(1, 0, 2, 6));
    waitPow(1'b0, 7000);
    checkVal(32'(convPower), 32'h0);
    $display("continuous test done");
    stop_test();
  end
endmodule : test_adc_conversion_sequencer
